// ### rtl/app_postproc.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
// Result post-processing: temperature gain, limit and delta checks
module app_postproc (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,

  // Conversion input
  input  wire logic        conv_valid,
  input  wire logic [15:0] conv_data,
  input  wire logic        conv_is_temp,

  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,

  // Stored result
  output logic             result_valid,
  output logic      [15:0] conversion_result,

  // Live check state
  output logic             low_limit_active,
  output logic             high_limit_active,

  // Interrupt
  output logic             irq
);

  // Software settings
  logic [15:0] low_threshold_value;
  logic [15:0] low_hysteresis_value;
  logic [15:0] high_threshold_value;
  logic [15:0] high_hysteresis_value;
  logic [15:0] delta_limit_value;
  logic [14:0] temp_gain_value;

  // Sticky flags and mask
  logic [31:0] interrupt_flags_a;
  logic [31:0] flags_mask;
  logic [31:0] flag_events;
  logic [31:0] next_flags;

  // Pipeline between gain and checks
  logic        corr_valid;
  logic [15:0] corr_data;
  logic        check_pulse;

  // Delta check state
  logic [15:0] prev_result;
  logic        prev_valid;
  logic [15:0] delta_abs;
  logic        delta_error_flag;

  // Limit check outputs
  logic        low_flag_state;
  logic        high_flag_state;
  logic        low_limit_flag;
  logic        high_limit_flag;

  // Decoded accesses
  logic        wr_low_thr;
  logic        wr_low_hyst;
  logic        wr_high_thr;
  logic        wr_high_hyst;
  logic        wr_delta;
  logic        wr_gain;
  logic        wr_mask;
  logic        rd_flags;
  logic [31:0] next_rdata;

  // Write decode
  assign wr_low_thr   = reg_wr && (reg_addr == app_pkg::OFS_LOW_THR);
  assign wr_low_hyst  = reg_wr && (reg_addr == app_pkg::OFS_LOW_HYST);
  assign wr_high_thr  = reg_wr && (reg_addr == app_pkg::OFS_HIGH_THR);
  assign wr_high_hyst = reg_wr && (reg_addr == app_pkg::OFS_HIGH_HYST);
  assign wr_delta     = reg_wr && (reg_addr == app_pkg::OFS_DELTA_LIMIT);
  assign wr_gain      = reg_wr && (reg_addr == app_pkg::OFS_TEMP_GAIN);
  assign wr_mask      = reg_wr && (reg_addr == app_pkg::OFS_FLAGS_MASK);

  // Read of the flag register clears it
  assign rd_flags     = reg_rd && (reg_addr == app_pkg::OFS_FLAGS_A);

  // Places the three event bits in the flag register layout
  function automatic logic [31:0] flag_layout(input logic low_b,
                                              input logic high_b,
                                              input logic delta_b);
    logic [31:0] v;
    v = '0;
    v[app_pkg::FLAG_LOW_POS]   = low_b;
    v[app_pkg::FLAG_HIGH_POS]  = high_b;
    v[app_pkg::FLAG_DELTA_POS] = delta_b;
    return v;
  endfunction

  // Lower limit settings, zero after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      low_threshold_value  <= app_pkg::RST_THRESHOLD;
      low_hysteresis_value <= app_pkg::RST_THRESHOLD;
    end else begin
      if (wr_low_thr) begin
        low_threshold_value <= reg_wdata[15:0];
      end
      if (wr_low_hyst) begin
        low_hysteresis_value <= reg_wdata[15:0];
      end
    end
  end

  // Upper limit settings, zero after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      high_threshold_value  <= app_pkg::RST_THRESHOLD;
      high_hysteresis_value <= app_pkg::RST_THRESHOLD;
    end else begin
      if (wr_high_thr) begin
        high_threshold_value <= reg_wdata[15:0];
      end
      if (wr_high_hyst) begin
        high_hysteresis_value <= reg_wdata[15:0];
      end
    end
  end

  // Delta limit setting, zero after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      delta_limit_value <= app_pkg::RST_THRESHOLD;
    end else if (wr_delta) begin
      delta_limit_value <= reg_wdata[15:0];
    end
  end

  // Temperature gain register, unity after reset
  always_ff @(posedge clk) begin
    if (srst) begin
      temp_gain_value <= app_pkg::RST_TEMP_GAIN;
    end else if (wr_gain) begin
      temp_gain_value <= reg_wdata[app_pkg::GAIN_W-1:0];
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_mask <= app_pkg::RST_MASK;
    end else if (wr_mask) begin
      flags_mask <= reg_wdata & flag_layout(1'b1, 1'b1, 1'b1);
    end
  end

  // Gain stage, corrects temperature results only
  app_gain_mul u_gain (
    .clk        (clk),
    .srst       (srst),
    .in_valid   (conv_valid),
    .in_data    (conv_data),
    .in_is_temp (conv_is_temp),
    .gain       (temp_gain_value),
    .out_valid  (corr_valid),
    .out_data   (corr_data)
  );

  // Result data register, the value software sees
  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_result <= '0;
    end else if (corr_valid) begin
      conversion_result <= corr_data;
    end
  end

  // Stored-result pulse, one cycle per new result
  always_ff @(posedge clk) begin
    if (srst) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= corr_valid;
    end
  end

  // Checks run once per newly stored result
  assign check_pulse = result_valid;

  // Lower threshold with hysteresis
  app_limit_hyst #(
    .IS_HIGH (1'b0)
  ) u_low (
    .clk        (clk),
    .srst       (srst),
    .check      (check_pulse),
    .sample     (conversion_result),
    .threshold  (low_threshold_value),
    .hysteresis (low_hysteresis_value),
    .flag       (low_flag_state),
    .hit        (low_limit_flag)
  );

  // Upper threshold with hysteresis
  app_limit_hyst #(
    .IS_HIGH (1'b1)
  ) u_high (
    .clk        (clk),
    .srst       (srst),
    .check      (check_pulse),
    .sample     (conversion_result),
    .threshold  (high_threshold_value),
    .hysteresis (high_hysteresis_value),
    .flag       (high_flag_state),
    .hit        (high_limit_flag)
  );

  // Magnitude of change from the previous stored result
  always_comb begin
    if (conversion_result >= prev_result) begin
      delta_abs = conversion_result - prev_result;
    end else begin
      delta_abs = prev_result - conversion_result;
    end
  end

  // Previous stored result, first one after reset has no predecessor
  always_ff @(posedge clk) begin
    if (srst) begin
      prev_result <= '0;
      prev_valid  <= 1'b0;
    end else if (check_pulse) begin
      prev_result <= conversion_result;
      prev_valid  <= 1'b1;
    end
  end

  // Delta check, one decision per stored result
  always_ff @(posedge clk) begin
    if (srst) begin
      delta_error_flag <= 1'b0;
    end else begin
      delta_error_flag <= check_pulse && prev_valid &&
                          (delta_abs > delta_limit_value);
    end
  end

  // Events gathered in flag layout
  assign flag_events = flag_layout(low_limit_flag, high_limit_flag, delta_error_flag);

  // Read clears, a new event in the same cycle wins
  always_comb begin
    next_flags = interrupt_flags_a;
    if (rd_flags) begin
      next_flags = '0;
    end
    next_flags = next_flags | flag_events;
  end

  // Sticky flag register
  always_ff @(posedge clk) begin
    if (srst) begin
      interrupt_flags_a <= app_pkg::RST_FLAGS;
    end else begin
      interrupt_flags_a <= next_flags;
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_flags & flags_mask);
    end
  end

  // Live low hysteresis state, two cycles after the check pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      low_limit_active <= 1'b0;
    end else begin
      low_limit_active <= low_flag_state;
    end
  end

  // Live high hysteresis state, two cycles after the check pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      high_limit_active <= 1'b0;
    end else begin
      high_limit_active <= high_flag_state;
    end
  end

  // Read data mux, unmapped and reserved bits read zero
  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      app_pkg::OFS_LOW_THR: begin
        next_rdata[15:0] = low_threshold_value;
      end
      app_pkg::OFS_LOW_HYST: begin
        next_rdata[15:0] = low_hysteresis_value;
      end
      app_pkg::OFS_HIGH_THR: begin
        next_rdata[15:0] = high_threshold_value;
      end
      app_pkg::OFS_HIGH_HYST: begin
        next_rdata[15:0] = high_hysteresis_value;
      end
      app_pkg::OFS_DELTA_LIMIT: begin
        next_rdata[15:0] = delta_limit_value;
      end
      app_pkg::OFS_TEMP_GAIN: begin
        next_rdata[app_pkg::GAIN_W-1:0] = temp_gain_value;
      end
      app_pkg::OFS_FLAGS_A: begin
        next_rdata = interrupt_flags_a;
      end
      app_pkg::OFS_FLAGS_MASK: begin
        next_rdata = flags_mask;
      end
      app_pkg::OFS_LIVE_STATE: begin
        next_rdata = flag_layout(low_flag_state, high_flag_state, 1'b0);
      end
      app_pkg::OFS_RESULT: begin
        next_rdata[15:0] = conversion_result;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // app_postproc

// ### rtl/app_pkg.sv
package app_pkg;

  // Register byte offsets
  localparam logic [15:0] OFS_LOW_THR     = 16'h20A8;
  localparam logic [15:0] OFS_LOW_HYST    = 16'h20AC;
  localparam logic [15:0] OFS_HIGH_THR    = 16'h20B0;
  localparam logic [15:0] OFS_HIGH_HYST   = 16'h20B4;
  localparam logic [15:0] OFS_DELTA_LIMIT = 16'h20B8;
  localparam logic [15:0] OFS_TEMP_GAIN   = 16'h2238;
  localparam logic [15:0] OFS_FLAGS_A     = 16'h20C0;
  localparam logic [15:0] OFS_FLAGS_MASK  = 16'h20C4;
  localparam logic [15:0] OFS_LIVE_STATE  = 16'h20C8;
  localparam logic [15:0] OFS_RESULT      = 16'h20CC;

  // Field widths and positions
  localparam int GAIN_W         = 15;
  localparam int GAIN_FRAC_BITS = 14;
  localparam int DATA_W         = 16;
  localparam int FLAG_LOW_POS   = 4;
  localparam int FLAG_HIGH_POS  = 5;
  localparam int FLAG_DELTA_POS = 6;

  // Reset values, zero gain code and saturation value
  localparam logic [15:0] RST_THRESHOLD = 16'h0000;
  localparam logic [14:0] RST_TEMP_GAIN = 15'h4000;
  localparam logic [14:0] GAIN_ZERO     = 15'h0000;
  localparam logic [31:0] RST_FLAGS     = 32'h0000_0000;
  localparam logic [31:0] RST_MASK      = 32'h0000_0000;
  localparam logic [15:0] DATA_MAX      = 16'hFFFF;

endpackage

// ### rtl/app_gain_mul.sv
`timescale 1ns/1ns
// Scales temperature results by the Q1.14 gain, passes other channels
module app_gain_mul (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // Incoming conversion
  input  wire logic                       in_valid,
  input  wire logic [app_pkg::DATA_W-1:0] in_data,
  input  wire logic                       in_is_temp,
  // Gain setting
  input  wire logic [app_pkg::GAIN_W-1:0] gain,
  // Corrected conversion
  output logic                            out_valid,
  output logic      [app_pkg::DATA_W-1:0] out_data
);

  logic [30:0] product;
  logic [16:0] scaled;
  logic [15:0] corrected;

  // Unsigned Q1.14 product, one code step is 2^-14
  assign product = 31'(in_data) * 31'(gain);
  assign scaled  = product[30:app_pkg::GAIN_FRAC_BITS];

  // Saturate above full scale, zero code forces zero
  always_comb begin
    if (gain == app_pkg::GAIN_ZERO) begin
      corrected = '0;
    end else if (scaled[16]) begin
      corrected = app_pkg::DATA_MAX;
    end else begin
      corrected = scaled[15:0];
    end
  end

  // Register output, only temperature channel is corrected
  always_ff @(posedge clk) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_data <= in_is_temp ? corrected : in_data;
      end
    end
  end

endmodule // app_gain_mul

// ### rtl/app_limit_hyst.sv
`timescale 1ns/1ns
// One threshold with hysteresis, low or high sense
module app_limit_hyst #(
  parameter bit IS_HIGH = 1'b0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Evaluation request
  input  wire logic        check,
  input  wire logic [15:0] sample,
  // Settings
  input  wire logic [15:0] threshold,
  input  wire logic [15:0] hysteresis,
  // Results
  output logic             flag,
  output logic             hit
);

  logic        trip;
  logic        release_ok;
  logic        next_flag;
  logic [16:0] sum_thr;
  logic [16:0] sum_smp;

  assign sum_thr = {1'b0, threshold} + {1'b0, hysteresis};
  assign sum_smp = {1'b0, sample} + {1'b0, hysteresis};

  // Trip and release conditions per sense
  always_comb begin
    if (IS_HIGH) begin
      trip       = sample > threshold;
      release_ok = sum_smp < {1'b0, threshold};
    end else begin
      trip       = sample < threshold;
      release_ok = {1'b0, sample} > sum_thr;
    end
    next_flag = flag ? !release_ok : trip;
  end

  // Flag state and per-evaluation hit
  always_ff @(posedge clk) begin
    if (srst) begin
      flag <= 1'b0;
      hit  <= 1'b0;
    end else begin
      hit <= check & next_flag;
      if (check) begin
        flag <= next_flag;
      end
    end
  end

endmodule // app_limit_hyst

// ### test/app_postproc_checker.sv
`timescale 1ns/1ns
// Port-level checks of the result post-processing block
module app_postproc_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Conversion input
  input wire logic        conv_valid,
  input wire logic [15:0] conv_data,
  input wire logic        conv_is_temp,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Results and state
  input wire logic        result_valid,
  input wire logic [15:0] conversion_result,
  input wire logic        low_limit_active,
  input wire logic        high_limit_active,
  input wire logic        irq
);
  logic [15:0] lthr, lhy, hthr, hhy;
  logic        mhigh;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Shadow of the limit settings and the high limit mask bit
  always_ff @(posedge clk) begin
    if (srst) begin
      lthr  <= 16'h0000;
      lhy   <= 16'h0000;
      hthr  <= 16'h0000;
      hhy   <= 16'h0000;
      mhigh <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        app_pkg::OFS_LOW_THR:    lthr <= reg_wdata[15:0];
        app_pkg::OFS_LOW_HYST:   lhy <= reg_wdata[15:0];
        app_pkg::OFS_HIGH_THR:   hthr <= reg_wdata[15:0];
        app_pkg::OFS_HIGH_HYST:  hhy <= reg_wdata[15:0];
        app_pkg::OFS_FLAGS_MASK: mhigh <= reg_wdata[app_pkg::FLAG_HIGH_POS];
        default: ;
      endcase
    end
  end
  AST_THR_RD: assert property ($past(reg_rd) && $past(reg_addr) == app_pkg::OFS_LOW_THR
    |-> reg_rdata == {16'h0000, $past(lthr)}) else $error("low threshold readback wrong");
  AST_PIPE: assert property (conv_valid |-> ##2 result_valid)
    else $error("stored result late or missing");
  AST_NONTEMP: assert property (conv_valid && !conv_is_temp
    |-> ##2 conversion_result == $past(conv_data, 2)) else $error("non-temperature result changed");
  AST_LOW_SET: assert property (result_valid && conversion_result < lthr
    |-> ##2 low_limit_active) else $error("low limit not entered");
  AST_LOW_REL: assert property (result_valid && {1'b0, conversion_result} > {1'b0, lthr} + lhy
    |-> ##2 !low_limit_active) else $error("low limit not released");
  AST_HIGH_SET: assert property (result_valid && conversion_result > hthr
    |-> ##2 high_limit_active) else $error("high limit not entered");
  AST_HIGH_REL: assert property (result_valid && {1'b0, conversion_result} + hhy < {1'b0, hthr}
    |-> ##2 !high_limit_active) else $error("high limit not released");
  AST_IRQ_HIGH: assert property (result_valid && conversion_result > hthr && mhigh
    |-> ##2 irq) else $error("interrupt missing on high limit");
  // Main scenarios reached
  cover property (conv_valid ##1 conv_valid);
  cover property (low_limit_active && irq);
  cover property ($past(reg_rd) && reg_rdata != 32'h0000_0000);
endmodule // app_postproc_checker

bind app_postproc app_postproc_checker i_chk (.clk(clk), .srst(srst), .conv_valid(conv_valid),
  .conv_data(conv_data), .conv_is_temp(conv_is_temp), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .result_valid(result_valid), .conversion_result(conversion_result),
  .low_limit_active(low_limit_active), .high_limit_active(high_limit_active), .irq(irq));

// ### test/app_postproc_tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the result post-processing block
module app_postproc_tb_top;
  logic        clk, srst, conv_valid, conv_is_temp, reg_wr, reg_rd;
  logic [15:0] conv_data, reg_addr, conversion_result;
  logic [31:0] reg_wdata, reg_rdata;
  logic        result_valid, low_limit_active, high_limit_active, irq;
  // Reference state
  logic [15:0] lthr, lhy, hthr, hhy, dlim, prev;
  logic [14:0] gain;
  logic [31:0] msk, fl;
  logic        lo, hi, have;
  int          n_fail, tests_run;
  logic [15:0] codes [7] = '{16'h4000, 16'h2000, 16'h7FFF, 16'h0000, 16'h4001, 16'h0001, 16'h3FFF};
  logic [15:0] ofs [8] = '{app_pkg::OFS_LOW_THR, app_pkg::OFS_LOW_HYST, app_pkg::OFS_HIGH_THR,
    app_pkg::OFS_HIGH_HYST, app_pkg::OFS_DELTA_LIMIT, app_pkg::OFS_TEMP_GAIN,
    app_pkg::OFS_FLAGS_A, app_pkg::OFS_FLAGS_MASK};

  app_postproc i_dut (.clk(clk), .srst(srst), .conv_valid(conv_valid), .conv_data(conv_data),
    .conv_is_temp(conv_is_temp), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_valid(result_valid),
    .conversion_result(conversion_result), .low_limit_active(low_limit_active),
    .high_limit_active(high_limit_active), .irq(irq));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Register write, reference settings follow
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    case (a)
      app_pkg::OFS_LOW_THR:     lthr = d[15:0];
      app_pkg::OFS_LOW_HYST:    lhy = d[15:0];
      app_pkg::OFS_HIGH_THR:    hthr = d[15:0];
      app_pkg::OFS_HIGH_HYST:   hhy = d[15:0];
      app_pkg::OFS_DELTA_LIMIT: dlim = d[15:0];
      app_pkg::OFS_TEMP_GAIN:   gain = d[14:0];
      app_pkg::OFS_FLAGS_MASK:  msk = d & 32'h0000_0070;
      default: ;
    endcase
  endtask

  // Register read, data compared in the following cycle
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // Expected stored result after gain correction
  function automatic logic [15:0] scaled(input logic [15:0] d, input logic t);
    logic [31:0] p;
    p = ({16'h0000, d} * {17'h00000, gain}) >> 14;
    return (!t) ? d : (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  // Reference hysteresis and sticky flags
  task automatic mdl(input logic [15:0] r);
    if (r < lthr) lo = 1'b1;
    else if ({1'b0, r} > {1'b0, lthr} + lhy) lo = 1'b0;
    if (r > hthr) hi = 1'b1;
    else if ({1'b0, r} + hhy < {1'b0, hthr}) hi = 1'b0;
    fl[4] = fl[4] | lo;
    fl[5] = fl[5] | hi;
    if (have && ((r > prev ? r - prev : prev - r) > dlim)) fl[6] = 1'b1;
    prev = r;
    have = 1'b1;
  endtask

  // One conversion, result and check state compared
  task automatic conv(input logic [15:0] d, input logic t);
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_data <= d;
    conv_is_temp <= t;
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
    #1 chk(result_valid, 1'b1);
    chk(conversion_result, scaled(d, t));
    mdl(scaled(d, t));
    repeat (2) @(posedge clk);
    #1 chk({irq, high_limit_active, low_limit_active}, {|(fl & msk), hi, lo});
    rd(app_pkg::OFS_RESULT, {16'h0000, scaled(d, t)});
    rd(app_pkg::OFS_LIVE_STATE, {26'h0, hi, lo, 4'h0});
  endtask

  // Flag read clears the sticky bits
  task automatic rdfl;
    rd(app_pkg::OFS_FLAGS_A, fl);
    fl = 32'h0000_0000;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  // Main sequence
  initial begin
    {srst, conv_valid, conv_is_temp, reg_wr, reg_rd, lo, hi, have} = 8'h80;
    {conv_data, reg_addr, lthr, lhy, hthr, hhy, dlim, prev} = '0;
    {reg_wdata, msk, fl} = '0;
    gain = 15'h4000;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(43869));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(ofs[i], i == 5 ? 32'h0000_4000 : 32'h0000_0000);
    wr(16'h2000, 32'hFFFF_FFFF);
    rd(16'h2000, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], $urandom);
      rd(ofs[i], i == 5 ? {17'h0, gain} : {16'h0, lthr, lhy, hthr, hhy, dlim} >> (16 * (4 - i)) & 32'hFFFF);
    end
    for (int i = 0; i < 7; i++) begin
      wr(app_pkg::OFS_TEMP_GAIN, {16'h0000, codes[i]});
      conv(16'hC000, 1'b1);
      conv(16'($urandom), 1'b1);
      conv(16'($urandom), 1'b0);
    end
    wr(app_pkg::OFS_LOW_THR, 32'h0000_1000);
    wr(app_pkg::OFS_LOW_HYST, 32'h0000_0100);
    wr(app_pkg::OFS_HIGH_THR, 32'h0000_C000);
    wr(app_pkg::OFS_HIGH_HYST, 32'h0000_0200);
    wr(app_pkg::OFS_DELTA_LIMIT, 32'h0000_8000);
    wr(app_pkg::OFS_FLAGS_MASK, 32'hFFFF_FFFF);
    rd(app_pkg::OFS_FLAGS_MASK, 32'h0000_0070);
    rdfl;
    foreach (codes[i]) conv(i == 0 ? 16'h0FFF : 16'h1100 + 16'(i == 2), 1'b0);
    rdfl;
    rdfl;
    conv(16'hC001, 1'b0);
    conv(16'hBE00, 1'b0);
    conv(16'hBDFF, 1'b0);
    conv(16'hC000, 1'b0);
    rdfl;
    // Back-to-back conversions
    @(posedge clk);
    conv_valid <= 1'b1;
    conv_is_temp <= 1'b0;
    conv_data <= 16'h0800;
    @(posedge clk);
    conv_data <= 16'hF000;
    @(posedge clk);
    conv_valid <= 1'b0;
    #1 chk(conversion_result, 16'h0800);
    @(posedge clk);
    #1 chk(conversion_result, 16'hF000);
    mdl(16'h0800);
    mdl(16'hF000);
    repeat (2) @(posedge clk);
    #1 chk({irq, high_limit_active, low_limit_active}, {|(fl & msk), hi, lo});
    rdfl;
    repeat (60) begin
      if ($urandom % 4 == 0) wr(ofs[$urandom % 8], $urandom);
      conv(16'($urandom), 1'($urandom));
      if ($urandom % 5 == 0) rdfl;
    end
    rdfl;
    finish_test;
  end
endmodule // app_postproc_tb_top
